// File: rtl/act_seq_pkg.sv
// constants and types shared by the loop activation sequencer and its timer
// assumes a single 50 MHz clock domain
package act_seq_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int T_ACT_S = 15;
	localparam int T_RESYNC_MS = 480;
	localparam int T_SILENCE_MS = 40;
	localparam int ACT_CYCLES = T_ACT_S * CLK_HZ;
	localparam int RESYNC_CYCLES = T_RESYNC_MS * (CLK_HZ / 1000);
	localparam int SILENCE_CYCLES = T_SILENCE_MS * (CLK_HZ / 1000);
	localparam int TMR_W = 30;

	// ------------------------------------------------------------
	// command and indication codes
	// ------------------------------------------------------------
	localparam logic [3:0] CMD_PUP_DR = 4'h0;
	localparam logic [3:0] CMD_RES = 4'h1;
	localparam logic [3:0] CMD_FA0 = 4'h4;
	localparam logic [3:0] CMD_PDN = 4'h5;
	localparam logic [3:0] CMD_AR = 4'h8;
	localparam logic [3:0] CMD_AC = 4'hC;
	localparam logic [3:0] CMD_DC = 4'hF;
	localparam logic [3:0] CMD_RESET = 4'hF;
	localparam logic [3:0] IND_DP_LSD = 4'h0;
	localparam logic [3:0] IND_EI = 4'h4;
	localparam logic [3:0] IND_SYNC = 4'h6;
	localparam logic [3:0] IND_AP = 4'h8;
	localparam logic [3:0] IND_AI = 4'hC;
	localparam logic [3:0] IND_DI = 4'hF;
	localparam logic [3:0] IND_RESET = 4'hF;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] ADDR_ACT_CTRL = 4'h0;
	localparam logic [3:0] ADDR_ACT_IND = 4'h1;
	localparam logic [3:0] ADDR_CONFIG = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam int CFG_W = 5;
	localparam int CFG_NT_BIT = 0;
	localparam int CFG_BP2_BIT = 1;
	localparam int CFG_TDIS_BIT = 2;
	localparam int CFG_SAIF_BIT = 3;
	localparam int CFG_CSO_BIT = 4;
	localparam logic [4:0] CFG_RESET = 5'h08;
	localparam int ST_WARM_BIT = 7;
	localparam int ST_PWR_BIT = 6;
	localparam int ST_TX_BIT = 5;

	// ------------------------------------------------------------
	// validation and send counts
	// ------------------------------------------------------------
	localparam logic [2:0] NT_VALID_LAST = 3'h2;
	localparam logic [2:0] DEA_VALID_LAST = 3'h2;
	localparam logic [2:0] DEA_SEND_LAST = 3'h3;

	typedef enum logic [3:0] {
		ST_POWER_DOWN,
		ST_RESET,
		ST_ACTIVATING,
		ST_BP2_HOLD,
		ST_NT_WAIT_AC,
		ST_NT_VALIDATE,
		ST_ACTIVE,
		ST_RESYNC,
		ST_LT_DEACT,
		ST_NT_DEACT,
		ST_SILENCE,
		ST_FAIL
	} seq_state_e;

endpackage

// File: rtl/activation_timer.sv
// loadable down counter used for every sequencer time-out
// assumes one clock; load wins over stop, one-cycle expiry pulse
`timescale 1ns/1ps
`default_nettype none
module activation_timer (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic load_in,
	input wire logic stop_in,
	input wire logic [act_seq_pkg::TMR_W-1:0] load_value_in,
	output logic running_out,
	output logic expired_out
);
	logic [act_seq_pkg::TMR_W-1:0] count_reg;

	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			count_reg <= '0;
			running_out <= 1'b0;
			expired_out <= 1'b0;
		end
		else if (ce_in)
		begin
			expired_out <= 1'b0;
			if (load_in)
			begin
				count_reg <= load_value_in;
				running_out <= 1'b1;
			end
			else if (stop_in)
				running_out <= 1'b0;
			else if (running_out)
			begin
				if (count_reg <= act_seq_pkg::TMR_W'(1))
				begin
					running_out <= 1'b0;
					expired_out <= 1'b1;
				end
				count_reg <= count_reg - act_seq_pkg::TMR_W'(1);
			end
		end
	end
endmodule
`default_nettype wire

// File: rtl/u_loop_activation_sequencer.sv
// activation / deactivation sequencer of a U-loop transceiver, LT or NT role
// assumes receiver status inputs come from on-chip logic on clock_in
//
// Behaviour
// R1 - first activation after power-on is a cold start, up to 15 s.
// R2 - activation after proper deactivation with power kept is a warm start.
// R3 - internal timers of 15 s, 480 ms and 40 ms at their phases.
// R4 - software can disable the 15 s timer to use its own time-out.
// R5 - LT: wake tone raises pending; when powered down the detect pin goes low.
// R6 - software programs configuration and powers up before activating.
// R7 - LT: activation request proceeds and starts the 15 s timer.
// R8 - LT: superframe sync on SN3 sets act to 1 and reports activation done.
// R9 - LT: 15 s expiry reports error then deactivated, back to full reset.
// R10 - breakpoint two holds act at 0 after sync until activation complete.
// R11 - LT: deactivation request sends dea 0; far-end silence reports deactivated.
// R12 - NT: wake tone raises line detect; when powered down the pin goes low.
// R13 - NT: activation request proceeds automatically and starts the 15 s timer.
// R14 - NT: sync on SL2 reports pending and sends SN3 with act 0.
// R15 - NT: software writes activation complete to send act 1.
// R16 - NT: activation done only after act 1 seen in 3 superframes.
// R17 - NT: 15 s expiry reports error then deactivated, back to full reset.
// R18 - NT: dea 0 seen in 3 consecutive superframes raises deactivation pending.
// R19 - NT: far-end loss stops transmission, then reset and deactivated.
// R20 - software programs the cold-start-only bit to 0.
// R21 - software selects line interface: 1 standard (default), 0 alternative.
// R22 - LT: deactivation sends dea 0 in 4 superframes before stopping.
// R23 - sync loss reports error, closes channels, retries 480 ms, then resets.
// R24 - command register returns to 0x0F at reset, deactivation and failure.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module u_loop_activation_sequencer #(
	parameter int ACT_CYCLES = act_seq_pkg::ACT_CYCLES,
	parameter int RESYNC_CYCLES = act_seq_pkg::RESYNC_CYCLES,
	parameter int SILENCE_CYCLES = act_seq_pkg::SILENCE_CYCLES
) (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic [act_seq_pkg::ADDR_W-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic wake_tone_in,
	input wire logic rx_signal_in,
	input wire logic rx_sync_in,
	input wire logic rx_sf_in,
	input wire logic rx_act_in,
	input wire logic rx_dea_in,
	output logic tx_enable_out,
	output logic tx_act_out,
	output logic tx_dea_out,
	output logic tx_cso_out,
	output logic saif_out,
	output logic channels_open_out,
	output logic powered_out,
	output logic warm_start_out,
	output logic line_signal_detect_n_out,
	output logic [3:0] ind_out,
	output logic ind_strobe_out
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	act_seq_pkg::seq_state_e state_reg, state_next;
	logic [3:0] cmd_reg;
	logic [act_seq_pkg::CFG_W-1:0] cfg_reg;
	logic [2:0] cnt_reg, cnt_next;
	logic warm_reg;
	logic cmd_wr;
	logic [3:0] cmd;
	logic nt_mode, bp2_en, tdis;
	logic ind_set;
	logic [3:0] ind_val;
	logic cmd_reinit, warm_set, warm_clr;
	logic tmr_load, tmr_stop, tmr_expired;
	logic [act_seq_pkg::TMR_W-1:0] tmr_value;
	logic act_timeout, sync_lost, in_sync_state;

	assign cmd_wr = wr_in && (addr_in == act_seq_pkg::ADDR_ACT_CTRL);
	assign cmd = wdata_in[3:0];
	assign nt_mode = cfg_reg[act_seq_pkg::CFG_NT_BIT];
	assign bp2_en = cfg_reg[act_seq_pkg::CFG_BP2_BIT];
	assign tdis = cfg_reg[act_seq_pkg::CFG_TDIS_BIT];
	// the 15 s limit is ignored while disabled, software times out instead
	assign act_timeout = tmr_expired && !tdis; // [R4]
	assign in_sync_state = (state_reg == act_seq_pkg::ST_BP2_HOLD)
		|| (state_reg == act_seq_pkg::ST_NT_WAIT_AC)
		|| (state_reg == act_seq_pkg::ST_NT_VALIDATE)
		|| (state_reg == act_seq_pkg::ST_ACTIVE);
	assign sync_lost = in_sync_state && !rx_sync_in;

	activation_timer u_timer (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.load_in(tmr_load),
		.stop_in(tmr_stop),
		.load_value_in(tmr_value),
		.running_out(),
		.expired_out(tmr_expired)
	);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		ind_set = 1'b0;
		ind_val = ind_out;
		cmd_reinit = 1'b0;
		warm_set = 1'b0;
		warm_clr = 1'b0;
		tmr_load = 1'b0;
		tmr_stop = 1'b0;
		tmr_value = act_seq_pkg::TMR_W'(ACT_CYCLES);
		case (state_reg)
			act_seq_pkg::ST_POWER_DOWN:
			begin
				if (wake_tone_in && ind_out != (nt_mode ? act_seq_pkg::IND_DP_LSD
					: act_seq_pkg::IND_AP))
				begin
					ind_set = 1'b1; // [R5] [R12]
					ind_val = nt_mode ? act_seq_pkg::IND_DP_LSD : act_seq_pkg::IND_AP;
				end
				if (cmd_wr && cmd == act_seq_pkg::CMD_PUP_DR)
					state_next = act_seq_pkg::ST_RESET;
			end
			act_seq_pkg::ST_RESET:
			begin
				if (wake_tone_in && ind_out != (nt_mode ? act_seq_pkg::IND_DP_LSD
					: act_seq_pkg::IND_AP))
				begin
					ind_set = 1'b1; // [R5] [R12]
					ind_val = nt_mode ? act_seq_pkg::IND_DP_LSD : act_seq_pkg::IND_AP;
				end
				if (cmd_wr && cmd == act_seq_pkg::CMD_AR)
				begin
					// warm_start_out tells the DSP whether to keep its coefficients
					state_next = act_seq_pkg::ST_ACTIVATING; // [R1] [R2] [R7] [R13]
					tmr_load = 1'b1; // [R3]
				end
				else if (cmd_wr && cmd == act_seq_pkg::CMD_DC)
					state_next = act_seq_pkg::ST_POWER_DOWN;
			end
			act_seq_pkg::ST_ACTIVATING:
			begin
				if (act_timeout)
					state_next = act_seq_pkg::ST_FAIL;
				else if (rx_sync_in && nt_mode)
				begin
					state_next = act_seq_pkg::ST_NT_WAIT_AC; // [R14]
					ind_set = 1'b1;
					ind_val = act_seq_pkg::IND_AP;
				end
				else if (rx_sync_in && bp2_en)
				begin
					state_next = act_seq_pkg::ST_BP2_HOLD; // [R10]
					ind_set = 1'b1;
					ind_val = act_seq_pkg::IND_SYNC;
					tmr_stop = 1'b1;
				end
				else if (rx_sync_in)
				begin
					state_next = act_seq_pkg::ST_ACTIVE; // [R8]
					ind_set = 1'b1;
					ind_val = act_seq_pkg::IND_AI;
					tmr_stop = 1'b1;
				end
			end
			act_seq_pkg::ST_BP2_HOLD:
			begin
				if (cmd_wr && cmd == act_seq_pkg::CMD_AC)
				begin
					state_next = act_seq_pkg::ST_ACTIVE; // [R10]
					ind_set = 1'b1;
					ind_val = act_seq_pkg::IND_AI;
				end
			end
			act_seq_pkg::ST_NT_WAIT_AC:
			begin
				if (act_timeout)
					state_next = act_seq_pkg::ST_FAIL; // [R17]
				else if (cmd_wr && cmd == act_seq_pkg::CMD_AC)
				begin
					state_next = act_seq_pkg::ST_NT_VALIDATE; // [R15]
					cnt_next = 3'h0;
				end
			end
			act_seq_pkg::ST_NT_VALIDATE:
			begin
				if (act_timeout)
					state_next = act_seq_pkg::ST_FAIL; // [R17]
				else if (rx_sf_in && !rx_act_in)
					cnt_next = 3'h0;
				else if (rx_sf_in && cnt_reg == act_seq_pkg::NT_VALID_LAST)
				begin
					state_next = act_seq_pkg::ST_ACTIVE; // [R16]
					ind_set = 1'b1;
					ind_val = act_seq_pkg::IND_AI;
					tmr_stop = 1'b1;
				end
				else if (rx_sf_in)
					cnt_next = cnt_reg + 3'h1;
			end
			act_seq_pkg::ST_ACTIVE:
			begin
				if (!nt_mode && cmd_wr && cmd == act_seq_pkg::CMD_PUP_DR)
				begin
					state_next = act_seq_pkg::ST_LT_DEACT; // [R11]
					cnt_next = 3'h0;
				end
				else if (!nt_mode && cmd_wr && cmd == act_seq_pkg::CMD_FA0)
					state_next = act_seq_pkg::ST_BP2_HOLD;
				else if (nt_mode && rx_sf_in && rx_dea_in)
					cnt_next = 3'h0;
				else if (nt_mode && rx_sf_in && cnt_reg == act_seq_pkg::DEA_VALID_LAST)
				begin
					state_next = act_seq_pkg::ST_NT_DEACT; // [R18]
					ind_set = 1'b1;
					ind_val = act_seq_pkg::IND_DP_LSD;
				end
				else if (nt_mode && rx_sf_in)
					cnt_next = cnt_reg + 3'h1;
			end
			act_seq_pkg::ST_RESYNC:
			begin
				if (tmr_expired || !rx_signal_in)
				begin
					state_next = act_seq_pkg::ST_RESET; // [R23]
					ind_set = 1'b1;
					ind_val = act_seq_pkg::IND_DI;
					cmd_reinit = 1'b1;
					warm_clr = 1'b1;
					tmr_stop = 1'b1;
				end
				else if (rx_sync_in)
				begin
					state_next = act_seq_pkg::ST_ACTIVE;
					ind_set = 1'b1;
					ind_val = act_seq_pkg::IND_AI;
					tmr_stop = 1'b1;
				end
			end
			act_seq_pkg::ST_LT_DEACT:
			begin
				if (rx_sf_in && cnt_reg == act_seq_pkg::DEA_SEND_LAST)
				begin
					state_next = act_seq_pkg::ST_SILENCE; // [R22]
					tmr_load = 1'b1;
					tmr_value = act_seq_pkg::TMR_W'(SILENCE_CYCLES);
				end
				else if (rx_sf_in)
					cnt_next = cnt_reg + 3'h1;
			end
			act_seq_pkg::ST_NT_DEACT:
			begin
				if (!rx_signal_in)
				begin
					state_next = act_seq_pkg::ST_SILENCE; // [R19]
					tmr_load = 1'b1;
					tmr_value = act_seq_pkg::TMR_W'(SILENCE_CYCLES);
				end
			end
			act_seq_pkg::ST_SILENCE:
			begin
				// far end must stay quiet for 40 ms; any signal restarts the wait
				tmr_value = act_seq_pkg::TMR_W'(SILENCE_CYCLES);
				if (rx_signal_in)
					tmr_load = 1'b1; // [R3]
				else if (tmr_expired)
				begin
					state_next = act_seq_pkg::ST_RESET; // [R11] [R19]
					ind_set = 1'b1;
					ind_val = act_seq_pkg::IND_DI;
					cmd_reinit = 1'b1;
					warm_set = 1'b1; // [R2]
				end
			end
			act_seq_pkg::ST_FAIL:
			begin
				state_next = act_seq_pkg::ST_RESET; // [R9] [R17]
				ind_set = 1'b1;
				ind_val = act_seq_pkg::IND_DI;
				cmd_reinit = 1'b1;
				warm_clr = 1'b1; // [R1]
			end
			default:
				state_next = act_seq_pkg::ST_RESET;
		endcase
		// events that override the per-state decisions
		if (state_next == act_seq_pkg::ST_FAIL)
		begin
			ind_set = 1'b1; // [R9] [R17]
			ind_val = act_seq_pkg::IND_EI;
			tmr_stop = 1'b1;
		end
		if (sync_lost)
		begin
			state_next = act_seq_pkg::ST_RESYNC; // [R23]
			ind_set = 1'b1;
			ind_val = act_seq_pkg::IND_EI;
			tmr_load = 1'b1;
			tmr_value = act_seq_pkg::TMR_W'(RESYNC_CYCLES);
		end
		if (cmd_wr && cmd == act_seq_pkg::CMD_RES
			&& state_reg != act_seq_pkg::ST_POWER_DOWN)
		begin
			state_next = act_seq_pkg::ST_RESET;
			warm_clr = 1'b1;
			tmr_stop = 1'b1;
			tmr_load = 1'b0;
		end
		if (cmd_wr && cmd == act_seq_pkg::CMD_PDN)
		begin
			state_next = act_seq_pkg::ST_POWER_DOWN;
			tmr_stop = 1'b1;
			tmr_load = 1'b0;
		end
		if (state_next != state_reg)
		begin
			if (state_next != act_seq_pkg::ST_NT_VALIDATE
				&& state_next != act_seq_pkg::ST_LT_DEACT)
				cnt_next = 3'h0;
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_reg <= act_seq_pkg::ST_POWER_DOWN;
			cnt_reg <= 3'h0;
		end
		else if (ce_in)
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	// ------------------------------------------------------------
	// indications and start type
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ind_out <= act_seq_pkg::IND_RESET;
			ind_strobe_out <= 1'b0;
		end
		else if (ce_in)
		begin
			ind_strobe_out <= ind_set;
			if (ind_set)
				ind_out <= ind_val;
		end
	end

	// power-on clears it, so the first activation is always cold
	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			warm_reg <= 1'b0; // [R1]
		else if (ce_in)
		begin
			if (warm_clr)
				warm_reg <= 1'b0;
			else if (warm_set)
				warm_reg <= 1'b1; // [R2]
		end
	end

	// ------------------------------------------------------------
	// line side outputs
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			tx_enable_out <= 1'b0;
			tx_act_out <= 1'b0;
			tx_dea_out <= 1'b1;
			channels_open_out <= 1'b0;
			powered_out <= 1'b0;
		end
		else if (ce_in)
		begin
			tx_enable_out <= !(state_next == act_seq_pkg::ST_POWER_DOWN
				|| state_next == act_seq_pkg::ST_RESET
				|| state_next == act_seq_pkg::ST_SILENCE
				|| state_next == act_seq_pkg::ST_FAIL); // [R19] [R22]
			tx_act_out <= (state_next == act_seq_pkg::ST_ACTIVE)
				|| (state_next == act_seq_pkg::ST_NT_VALIDATE); // [R8] [R14]
			tx_dea_out <= (state_next != act_seq_pkg::ST_LT_DEACT); // [R11]
			channels_open_out <= (state_next == act_seq_pkg::ST_ACTIVE); // [R23]
			powered_out <= (state_next != act_seq_pkg::ST_POWER_DOWN);
		end
	end

	// detect pin is only pulled while powered down; power-up releases it
	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			line_signal_detect_n_out <= 1'b1;
		else if (ce_in)
		begin
			if (state_reg != act_seq_pkg::ST_POWER_DOWN)
				line_signal_detect_n_out <= 1'b1;
			else if (wake_tone_in)
				line_signal_detect_n_out <= 1'b0; // [R5] [R12]
		end
	end

	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------
	// a hardware re-initialisation wins over a same-cycle write
	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			cmd_reg <= act_seq_pkg::CMD_RESET; // [R24]
		else if (ce_in)
		begin
			if (cmd_reinit)
				cmd_reg <= act_seq_pkg::CMD_RESET; // [R24]
			else if (cmd_wr)
				cmd_reg <= cmd;
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			cfg_reg <= act_seq_pkg::CFG_RESET; // [R21]
		else if (ce_in && wr_in && addr_in == act_seq_pkg::ADDR_CONFIG)
			cfg_reg <= wdata_in[act_seq_pkg::CFG_W-1:0];
	end

	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			rdata_out <= 8'h00;
		else if (ce_in)
		begin
			rdata_out <= 8'h00;
			if (rd_in)
			begin
				case (addr_in)
					act_seq_pkg::ADDR_ACT_CTRL: rdata_out <= {4'h0, cmd_reg};
					act_seq_pkg::ADDR_ACT_IND: rdata_out <= {4'h0, ind_out};
					act_seq_pkg::ADDR_CONFIG: rdata_out <= {3'h0, cfg_reg};
					act_seq_pkg::ADDR_STATUS: rdata_out <= {warm_reg, powered_out,
						tx_enable_out, 1'b0, state_reg};
					default: rdata_out <= 8'h00;
				endcase
			end
		end
	end

	assign warm_start_out = warm_reg;
	assign tx_cso_out = cfg_reg[act_seq_pkg::CFG_CSO_BIT]; // [R20]
	assign saif_out = cfg_reg[act_seq_pkg::CFG_SAIF_BIT]; // [R21]

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!arst_n_in || !ce_in);

	cmd_reinit_di_a: assert property ( // [R24]
		(ind_strobe_out && ind_out == act_seq_pkg::IND_DI)
		|-> cmd_reg == act_seq_pkg::CMD_RESET)
		else $error("command register not reinitialised with deactivated");
	fail_ei_di_a: assert property ( // [R9] [R17]
		(state_reg == act_seq_pkg::ST_ACTIVATING && act_timeout)
		|=> ind_out == act_seq_pkg::IND_EI ##1 ind_out == act_seq_pkg::IND_DI
		&& state_reg == act_seq_pkg::ST_RESET)
		else $error("time-out did not give error then deactivated");
	lt_sync_act_a: assert property ( // [R8]
		(state_reg == act_seq_pkg::ST_ACTIVATING && !nt_mode && !bp2_en
		&& rx_sync_in && !act_timeout && !cmd_wr)
		|=> tx_act_out && channels_open_out && ind_out == act_seq_pkg::IND_AI)
		else $error("sync on SN3 did not activate");
	bp2_hold_a: assert property ( // [R10]
		(state_reg == act_seq_pkg::ST_BP2_HOLD) |-> !tx_act_out && tx_enable_out)
		else $error("act sent during breakpoint hold");
	nt_ai_valid_a: assert property ( // [R16]
		(nt_mode && $changed(ind_out) && ind_out == act_seq_pkg::IND_AI
		&& $past(state_reg) == act_seq_pkg::ST_NT_VALIDATE)
		|-> $past(cnt_reg) == act_seq_pkg::NT_VALID_LAST && $past(rx_act_in))
		else $error("activation done before three act superframes");
	lt_dea_send_a: assert property ( // [R22]
		(state_reg == act_seq_pkg::ST_LT_DEACT) |-> tx_enable_out && !tx_dea_out)
		else $error("deactivation superframes not sent with dea 0");
	lsd_pin_a: assert property ( // [R5] [R12]
		(state_reg == act_seq_pkg::ST_POWER_DOWN && wake_tone_in)
		|=> !line_signal_detect_n_out)
		else $error("detect pin not pulled low on wake tone");
	resync_closed_a: assert property ( // [R23]
		(state_reg == act_seq_pkg::ST_RESYNC) |-> !channels_open_out
		&& ind_out == act_seq_pkg::IND_EI)
		else $error("channels open while resynchronising");
	nt_stop_tx_a: assert property ( // [R19]
		(state_reg == act_seq_pkg::ST_NT_DEACT && !rx_signal_in && !cmd_wr)
		|=> !tx_enable_out)
		else $error("transmission not stopped on far-end loss");
	warm_after_di_a: assert property ( // [R2]
		(state_reg == act_seq_pkg::ST_SILENCE && !rx_signal_in && tmr_expired)
		|=> warm_reg && ind_out == act_seq_pkg::IND_DI)
		else $error("proper deactivation did not arm warm start");

	reach_active_c: cover property (state_reg == act_seq_pkg::ST_ACTIVE);
	reach_bp2_c: cover property (state_reg == act_seq_pkg::ST_BP2_HOLD);
	reach_resync_c: cover property (state_reg == act_seq_pkg::ST_RESYNC);
	reach_fail_c: cover property (state_reg == act_seq_pkg::ST_FAIL);
endmodule
`default_nettype wire

// File: tb/far_end_model.sv
// far-end loop transceiver model feeding the sequencer's receive status lines
// assumes the bench steers it through far_on_in, act_bit_in and dea_bit_in
`timescale 1ns/1ps
`default_nettype none
module far_end_model #(
	parameter int SF_CYCLES = 8
) (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic far_on_in,
	input wire logic act_bit_in,
	input wire logic dea_bit_in,
	output logic rx_signal_out,
	output logic rx_sync_out,
	output logic rx_sf_out,
	output logic rx_act_out,
	output logic rx_dea_out
);
	logic [7:0] sf_cnt_reg;

	// the far end goes silent as soon as it is told to stop sending
	assign rx_signal_out = far_on_in;
	assign rx_sync_out = far_on_in;

	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			sf_cnt_reg <= 8'h00;
		else if (!rx_sync_out || sf_cnt_reg == 8'(SF_CYCLES - 1))
			sf_cnt_reg <= 8'h00;
		else
			sf_cnt_reg <= sf_cnt_reg + 8'h01;
	end

	assign rx_sf_out = rx_sync_out && sf_cnt_reg == 8'(SF_CYCLES - 1);
	// bits mean nothing between pulses, so show the inverse there
	assign rx_act_out = rx_sf_out ? act_bit_in : !act_bit_in;
	assign rx_dea_out = rx_sf_out ? dea_bit_in : !dea_bit_in;
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the loop activation sequencer, LT then NT role
// assumes 50 MHz clock, shortened timer parameters and the far-end model
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int ACT_N = 200;
	logic clock_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [3:0] addr_in = 4'h0;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic wake_tone_in = 1'b0;
	logic far_on = 1'b0;
	logic act_bit = 1'b0;
	logic dea_bit = 1'b1;
	logic [7:0] rdata_out;
	logic rx_signal_in, rx_sync_in, rx_sf_in, rx_act_in, rx_dea_in;
	logic tx_enable_out, tx_act_out, tx_dea_out, channels_open_out, powered_out;
	logic warm_start_out, line_signal_detect_n_out, ind_strobe_out;
	logic [3:0] ind_out;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int sf_count = 0;

	u_loop_activation_sequencer #(.ACT_CYCLES(ACT_N), .RESYNC_CYCLES(50),
		.SILENCE_CYCLES(20)) u_dut (.clock_in, .arst_n_in, .ce_in(1'b1), .addr_in,
		.wdata_in, .wr_in, .rd_in, .rdata_out, .wake_tone_in, .rx_signal_in,
		.rx_sync_in, .rx_sf_in, .rx_act_in, .rx_dea_in, .tx_enable_out, .tx_act_out,
		.tx_dea_out, .tx_cso_out(), .saif_out(), .channels_open_out, .powered_out,
		.warm_start_out, .line_signal_detect_n_out, .ind_out, .ind_strobe_out);

	far_end_model u_far (.clock_in, .arst_n_in, .far_on_in(far_on), .act_bit_in(act_bit),
		.dea_bit_in(dea_bit), .rx_signal_out(rx_signal_in), .rx_sync_out(rx_sync_in),
		.rx_sf_out(rx_sf_in), .rx_act_out(rx_act_in), .rx_dea_out(rx_dea_in));

	always #10 clock_in = ~clock_in;

	always @(posedge clock_in)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			num_errors++;
			finish_test();
		end
	end

	task automatic finish_test;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t ns: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		@(negedge clock_in);
		chk(rdata_out, exp);
	endtask

	// 8'hEE stands for no indication at all; superframes are counted on the way
	task automatic expect_ind(input int lim, input logic [7:0] exp);
		logic [7:0] seen;
		seen = 8'hEE;
		sf_count = 0;
		for (int i = 0; i < lim && seen === 8'hEE; i++)
		begin
			@(negedge clock_in);
			if (ind_strobe_out === 1'b1)
				seen = {4'h0, ind_out};
			else if (rx_sf_in === 1'b1)
				sf_count++;
		end
		chk(seen, exp);
	endtask

	task automatic test_reset_values;
		rd_chk(4'h0, 8'h0F);
		rd_chk(4'h1, 8'h0F);
		rd_chk(4'h2, {3'h0, act_seq_pkg::CFG_RESET});
		rd_chk(4'h3, 8'h00);
		rd_chk(4'h7, 8'h00);
		chk({6'h00, tx_dea_out, tx_enable_out}, 8'h02);
	endtask

	task automatic test_wake;
		@(posedge clock_in);
		wake_tone_in <= 1'b1;
		expect_ind(10, 8'h08);
		chk({7'h00, line_signal_detect_n_out}, 8'h00);
		@(posedge clock_in);
		wake_tone_in <= 1'b0;
	endtask

	task automatic test_lt_act;
		wr_reg(4'h0, 8'h00);
		wr_reg(4'h0, 8'h08);
		@(negedge clock_in);
		chk({5'h00, tx_enable_out, powered_out, warm_start_out}, 8'h06);
		@(posedge clock_in);
		far_on <= 1'b1;
		expect_ind(40, 8'h0C);
		chk({6'h00, tx_act_out, channels_open_out}, 8'h03);
	endtask

	task automatic test_lt_deact;
		int sf_seen;
		sf_seen = 0;
		wr_reg(4'h0, 8'h00);
		@(negedge clock_in);
		chk({7'h00, tx_dea_out}, 8'h00);
		for (int i = 0; i < 100 && tx_enable_out === 1'b1; i++)
		begin
			if (rx_sf_in === 1'b1)
				sf_seen++;
			@(negedge clock_in);
		end
		chk(8'(sf_seen), 8'h04);
		@(posedge clock_in);
		far_on <= 1'b0;
		expect_ind(60, 8'h0F);
		rd_chk(4'h0, 8'h0F);
		chk({7'h00, warm_start_out}, 8'h01);
	endtask

	task automatic test_timeout;
		wr_reg(4'h0, 8'h08);
		expect_ind(ACT_N + 20, 8'h04);
		expect_ind(2, 8'h0F);
		rd_chk(4'h3, 8'h41);
	endtask

	// breakpoint hold, release, then sync loss with the far end gone
	task automatic test_bp2;
		wr_reg(4'h2, 8'h0A);
		wr_reg(4'h0, 8'h08);
		@(posedge clock_in);
		far_on <= 1'b1;
		expect_ind(20, 8'h06);
		chk({6'h00, tx_enable_out, tx_act_out}, 8'h02);
		wr_reg(4'h0, 8'h0C);
		expect_ind(4, 8'h0C);
		chk({6'h00, tx_act_out, channels_open_out}, 8'h03);
		@(posedge clock_in);
		far_on <= 1'b0;
		expect_ind(4, 8'h04);
		chk({7'h00, channels_open_out}, 8'h00);
		expect_ind(2, 8'h0F);
	endtask

	task automatic test_timer_off;
		wr_reg(4'h2, 8'h0C);
		wr_reg(4'h0, 8'h08);
		expect_ind(ACT_N + 20, 8'hEE);
		wr_reg(4'h0, 8'h01);
		wr_reg(4'h2, 8'h09);
		repeat (5) @(negedge clock_in);
	endtask

	task automatic test_nt;
		wr_reg(4'h0, 8'h08);
		@(posedge clock_in);
		far_on <= 1'b1;
		expect_ind(40, 8'h08);
		chk({6'h00, tx_enable_out, tx_act_out}, 8'h02);
		wr_reg(4'h0, 8'h0C);
		@(negedge clock_in);
		chk({7'h00, tx_act_out}, 8'h01);
		@(posedge clock_in);
		act_bit <= 1'b1;
		expect_ind(40, 8'h0C);
		chk({sf_count[6:0], channels_open_out}, 8'h07);
		@(posedge clock_in);
		dea_bit <= 1'b0;
		expect_ind(40, 8'h00);
		chk(8'(sf_count), 8'h03);
		@(posedge clock_in);
		far_on <= 1'b0;
		expect_ind(60, 8'h0F);
		chk({7'h00, tx_enable_out}, 8'h00);
	endtask

	initial
	begin
		repeat (8) @(posedge clock_in);
		arst_n_in <= 1'b1;
		test_reset_values();
		test_wake();
		test_lt_act();
		test_lt_deact();
		test_timeout();
		test_bp2();
		test_timer_off();
		test_nt();
		finish_test();
	end
endmodule
`default_nettype wire
